//--- include/dcc_pkg.sv
// Function
// - Commit bit one copies staged settings live.
// - Commit bit zero leaves live settings alone.
// - Format, delays, frame setting, length move together.
// - Each channel muted until its delay fills.
// - Control mute bits act immediately when written.
// - Frame mode ignores the per-channel delay registers.
// - Sequential reads auto-increment from control to commit.
// - Control bits select mute pair and format.
// - Channel delay is thirteen bits, up to 8191.
package dcc_pkg;

    // ------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------
    localparam logic [3:0] DCC_OFS_CTRL = 4'h1;
    localparam logic [3:0] DCC_OFS_RDLY_HI = 4'h2;
    localparam logic [3:0] DCC_OFS_RDLY_LO = 4'h3;
    localparam logic [3:0] DCC_OFS_LDLY_HI = 4'h4;
    localparam logic [3:0] DCC_OFS_LDLY_LO = 4'h5;
    localparam logic [3:0] DCC_OFS_FRAME = 4'h6;
    localparam logic [3:0] DCC_OFS_LEN = 4'h7;
    localparam logic [3:0] DCC_OFS_COMMIT = 4'h8;

    // ------------------------------------------------------------
    // Field positions, masks and reset values.
    // ------------------------------------------------------------
    localparam int DCC_CTRL_MUTE_R_BIT = 7;
    localparam int DCC_CTRL_MUTE_L_BIT = 6;
    localparam int DCC_FRAME_EN_BIT = 7;
    localparam int DCC_FRAME_RATE_BIT = 6;
    localparam int DCC_COMMIT_BIT = 0;
    localparam logic [7:0] DCC_HI_MASK = 8'h1F;
    localparam logic [7:0] DCC_LEN_MASK = 8'h3F;
    localparam logic [7:0] DCC_REG_RESET = 8'h00;
    localparam logic [5:0] DCC_LEN_MAX = 6'h18;
    localparam logic [12:0] DCC_DELAY_MAX = 13'h1FFF;

    // Upper four bits of the bus address; the value is arbitrary.
    localparam logic [3:0] DCC_BUS_ADDR_BASE = 4'h5;

    // ------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DCC_FMT_I2S = 2'b00,
        DCC_FMT_RIGHT_ALIGNED = 2'b01,
        DCC_FMT_LEFT_ALIGNED = 2'b10,
        DCC_FMT_BYPASS = 2'b11
    } dcc_fmt_t;

    typedef enum logic [2:0] {
        DCC_ST_IDLE = 3'b000,
        DCC_ST_RX = 3'b001,
        DCC_ST_ACK = 3'b010,
        DCC_ST_TX = 3'b011,
        DCC_ST_TXACK = 3'b100
    } dcc_state_t;

    // Active configuration handed to the delay engine.
    typedef struct packed {
        dcc_fmt_t fmt;
        logic frame_mode;
        logic [6:0] frame_setting;
        logic [5:0] right_aligned_format_len;
        logic [12:0] right_delay;
        logic [12:0] left_delay;
    } dcc_cfg_t;

    // Frame delay in samples, clamped to the largest delay.
    function automatic logic [12:0] dcc_frame_samples(input logic [6:0] f);
        int unsigned rate;
        int unsigned frames;
        int unsigned total;
        case (f[5:3])
            3'h0: rate = 32000;
            3'h1: rate = 44100;
            3'h2: rate = 48000;
            3'h3: rate = 88200;
            3'h4: rate = 96000;
            3'h5: rate = 176400;
            default: rate = 192000;
        endcase
        frames = int'(f[2:0]) + 1;
        // The faster frame rate is 60000/1001 Hz; products stay below two to the 31st.
        if (f[DCC_FRAME_RATE_BIT])
            total = (frames * rate * 1001) / 60000;
        else
            total = (frames * rate) / 50;
        if (total > 8191)
            return DCC_DELAY_MAX;
        return total[12:0];
    endfunction : dcc_frame_samples

endpackage : dcc_pkg

//--- rtl/dcc_fill_mute.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Holds one channel muted while its new delay line fills.
// ------------------------------------------------------------
module dcc_fill_mute (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Control.
    input wire logic load,
    input wire logic [12:0] load_value,
    input wire logic sample_tick,
    // Status.
    output logic filling
);

    logic [12:0] count_q; // Samples still to enter.
    logic [12:0] count_d;

    // Load on a committed change, then count incoming samples down.
    always_comb
    begin
        count_d = count_q;
        if (load)
        begin
            count_d = load_value;
        end
        else if (sample_tick && count_q != 13'h0000)
        begin
            count_d = count_q - 13'h0001;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            count_q <= 13'h0000;
        else if (ce)
            count_q <= count_d;
    end

    // A zero delay needs no fill, so it never mutes.
    assign filling = (count_q != 13'h0000);

endmodule : dcc_fill_mute

//--- rtl/dcc_regs.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-wire bus register file with atomic settings commit.
// ------------------------------------------------------------
module dcc_regs (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Two-wire bus pins; the data pin is open drain.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Address strap pins.
    input wire logic [2:0] addr_pins,
    // Sample strobes from the audio receiver, same clock.
    input wire logic right_sample_tick,
    input wire logic left_sample_tick,
    // Active settings towards the delay engine.
    output dcc_pkg::dcc_cfg_t active_cfg,
    output logic commit_pulse,
    output logic right_mute,
    output logic left_mute
);

    // ------------------------------------------------------------
    // Pin synchronisers and glitch filter.
    // ------------------------------------------------------------
    logic [4:0] sync1_q; // First stage, read only by the second.
    logic [4:0] sync2_q;
    logic [4:0] sync3_q;
    logic [4:0] pins_q; // Filtered levels: {addr, sda, scl}.
    logic [4:0] pins_prev_q; // Filtered levels one cycle back.
    logic [4:0] pins_d;

    // A level change counts only once stages two and three agree.
    always_comb
    begin
        for (int i = 0; i < 5; i++)
            pins_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : pins_q[i];
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_q <= 5'h03;
            sync2_q <= 5'h03;
            sync3_q <= 5'h03;
            pins_q <= 5'h03;
            pins_prev_q <= 5'h03;
        end
        else if (ce)
        begin
            sync1_q <= {addr_pins, sda_i, scl_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pins_q <= pins_d;
            pins_prev_q <= pins_q;
        end
    end

    // Bus events decoded from the filtered levels.
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sda_now;
    assign sda_now = pins_q[1];
    assign scl_rise = pins_q[0] & ~pins_prev_q[0];
    assign scl_fall = ~pins_q[0] & pins_prev_q[0];
    assign bus_start = pins_q[0] & pins_prev_q[0] & pins_prev_q[1] & ~pins_q[1];
    assign bus_stop = pins_q[0] & pins_prev_q[0] & ~pins_prev_q[1] & pins_q[1];

    // ------------------------------------------------------------
    // Register storage and read decode.
    // ------------------------------------------------------------
    logic [7:0] regs_q [1:8]; // Staged registers, indexed by offset.
    logic [7:0] regs_d [1:8];
    logic [3:0] ptr_q; // Register pointer.
    logic [7:0] shift_q; // Byte shift register.
    logic wr_en; // Write of shift_q into the pointed register.

    // Read value with unused upper bits of the delay high and length registers forced to zero.
    function automatic logic [7:0] reg_read(input logic [3:0] ofs, input logic [7:0] r [1:8]);
        logic [7:0] v;
        v = 8'h00;
        if (ofs >= dcc_pkg::DCC_OFS_CTRL && ofs <= dcc_pkg::DCC_OFS_COMMIT)
            v = r[ofs];
        if (ofs == dcc_pkg::DCC_OFS_RDLY_HI || ofs == dcc_pkg::DCC_OFS_LDLY_HI)
            v = v & dcc_pkg::DCC_HI_MASK;
        if (ofs == dcc_pkg::DCC_OFS_LEN)
            v = v & dcc_pkg::DCC_LEN_MASK;
        return v;
    endfunction : reg_read

    // Writes outside the map are dropped; mute bits act as soon as stored.
    always_comb
    begin
        for (int i = 1; i <= 8; i++)
            regs_d[i] = regs_q[i];
        if (wr_en && ptr_q >= dcc_pkg::DCC_OFS_CTRL && ptr_q <= dcc_pkg::DCC_OFS_COMMIT)
            regs_d[ptr_q] = shift_q;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 1; i <= 8; i++)
                regs_q[i] <= dcc_pkg::DCC_REG_RESET;
        end
        else if (ce)
        begin
            for (int i = 1; i <= 8; i++)
                regs_q[i] <= regs_d[i];
        end
    end

    // ------------------------------------------------------------
    // Bus slave state machine.
    // ------------------------------------------------------------
    dcc_pkg::dcc_state_t state_q;
    dcc_pkg::dcc_state_t state_d;
    logic [3:0] ptr_d;
    logic [7:0] shift_d;
    logic [3:0] bits_q; // Bits moved in the current byte.
    logic [3:0] bits_d;
    logic addr_byte_q; // Next received byte is the address.
    logic addr_byte_d;
    logic ptr_byte_q; // Next received byte is the pointer.
    logic ptr_byte_d;
    logic read_q; // Current transfer is a read.
    logic read_d;
    logic pull_q; // Pull the data line low.
    logic pull_d;
    logic [7:0] rd_now;
    assign rd_now = reg_read(ptr_q, regs_q);

    always_comb
    begin
        state_d = state_q;
        ptr_d = ptr_q;
        shift_d = shift_q;
        bits_d = bits_q;
        addr_byte_d = addr_byte_q;
        ptr_byte_d = ptr_byte_q;
        read_d = read_q;
        pull_d = pull_q;
        wr_en = 1'b0;
        if (bus_start)
        begin
            // A start, repeated or not, always begins a new address byte.
            state_d = dcc_pkg::DCC_ST_RX;
            bits_d = 4'h0;
            addr_byte_d = 1'b1;
            pull_d = 1'b0;
        end
        else if (bus_stop)
        begin
            state_d = dcc_pkg::DCC_ST_IDLE;
            pull_d = 1'b0;
        end
        else
        begin
            case (state_q)
                dcc_pkg::DCC_ST_IDLE:
                begin
                    pull_d = 1'b0;
                end
                dcc_pkg::DCC_ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_d = {shift_q[6:0], sda_now};
                        bits_d = bits_q + 4'h1;
                    end
                    else if (scl_fall && bits_q == 4'h8)
                    begin
                        bits_d = 4'h0;
                        state_d = dcc_pkg::DCC_ST_ACK;
                        pull_d = 1'b1;
                        if (addr_byte_q)
                        begin
                            addr_byte_d = 1'b0;
                            read_d = shift_q[0];
                            ptr_byte_d = ~shift_q[0];
                            // Another device's address: stay off the bus.
                            if (shift_q[7:1] != {dcc_pkg::DCC_BUS_ADDR_BASE, pins_q[4:2]})
                            begin
                                state_d = dcc_pkg::DCC_ST_IDLE;
                                pull_d = 1'b0;
                            end
                        end
                        else if (ptr_byte_q)
                        begin
                            ptr_byte_d = 1'b0;
                            ptr_d = shift_q[3:0];
                        end
                        else
                        begin
                            // Each burst byte aimed at 0x01..0x08 lands in the pointed register, then the pointer steps on.
                            wr_en = 1'b1;
                            ptr_d = ptr_q + 4'h1;
                        end
                    end
                end
                dcc_pkg::DCC_ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (read_q)
                        begin
                            state_d = dcc_pkg::DCC_ST_TX;
                            shift_d = rd_now;
                            pull_d = ~rd_now[7];
                        end
                        else
                        begin
                            state_d = dcc_pkg::DCC_ST_RX;
                            pull_d = 1'b0;
                        end
                    end
                end
                dcc_pkg::DCC_ST_TX:
                begin
                    if (scl_fall)
                    begin
                        bits_d = bits_q + 4'h1;
                        if (bits_q == 4'h7)
                        begin
                            bits_d = 4'h0;
                            state_d = dcc_pkg::DCC_ST_TXACK;
                            pull_d = 1'b0;
                        end
                        else
                        begin
                            shift_d = {shift_q[6:0], 1'b0};
                            pull_d = ~shift_q[6];
                        end
                    end
                end
                dcc_pkg::DCC_ST_TXACK:
                begin
                    if (scl_rise)
                    begin
                        if (sda_now)
                            state_d = dcc_pkg::DCC_ST_IDLE;
                        else
                        begin
                            // Acknowledged: step to the next register.
                            ptr_d = ptr_q + 4'h1;
                            state_d = dcc_pkg::DCC_ST_ACK;
                        end
                    end
                end
                default:
                begin
                    state_d = dcc_pkg::DCC_ST_IDLE;
                    pull_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= dcc_pkg::DCC_ST_IDLE;
            ptr_q <= 4'h0;
            shift_q <= 8'h00;
            bits_q <= 4'h0;
            addr_byte_q <= 1'b0;
            ptr_byte_q <= 1'b0;
            read_q <= 1'b0;
            pull_q <= 1'b0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            ptr_q <= ptr_d;
            shift_q <= shift_d;
            bits_q <= bits_d;
            addr_byte_q <= addr_byte_d;
            ptr_byte_q <= ptr_byte_d;
            read_q <= read_d;
            pull_q <= pull_d;
        end
    end

    // Open drain: the line is only ever pulled low.
    assign sda_o = 1'b0;
    assign sda_oe_n = ~pull_q;

    // ------------------------------------------------------------
    // Staged settings and atomic commit.
    // ------------------------------------------------------------
    dcc_pkg::dcc_cfg_t staged;
    dcc_pkg::dcc_cfg_t cfg_q;
    dcc_pkg::dcc_cfg_t cfg_d;
    logic commit_q;
    logic commit_d;
    logic [12:0] frame_delay;
    logic [5:0] len_raw;

    assign frame_delay = dcc_pkg::dcc_frame_samples(regs_q[dcc_pkg::DCC_OFS_FRAME][6:0]);
    assign len_raw = regs_q[dcc_pkg::DCC_OFS_LEN][5:0];

    // Build the full settings word from the register file.
    always_comb
    begin
        staged.fmt = dcc_pkg::dcc_fmt_t'(regs_q[dcc_pkg::DCC_OFS_CTRL][1:0]);
        staged.frame_mode = regs_q[dcc_pkg::DCC_OFS_FRAME][dcc_pkg::DCC_FRAME_EN_BIT];
        staged.frame_setting = regs_q[dcc_pkg::DCC_OFS_FRAME][6:0];
        // Lengths past the largest are limited rather than wrapped.
        staged.right_aligned_format_len = (len_raw > dcc_pkg::DCC_LEN_MAX) ? dcc_pkg::DCC_LEN_MAX : len_raw;
        staged.right_delay = {regs_q[dcc_pkg::DCC_OFS_RDLY_HI][4:0], regs_q[dcc_pkg::DCC_OFS_RDLY_LO]};
        staged.left_delay = {regs_q[dcc_pkg::DCC_OFS_LDLY_HI][4:0], regs_q[dcc_pkg::DCC_OFS_LDLY_LO]};
        if (staged.frame_mode)
        begin
            staged.right_delay = frame_delay;
            staged.left_delay = frame_delay;
        end
    end

    // Only the write cycle itself triggers, so later staged writes wait.
    always_comb
    begin
        cfg_d = cfg_q;
        commit_d = 1'b0;
        if (wr_en && ptr_q == dcc_pkg::DCC_OFS_COMMIT && shift_q[dcc_pkg::DCC_COMMIT_BIT])
        begin
            cfg_d = staged;
            commit_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cfg_q <= '0;
            commit_q <= 1'b0;
        end
        else if (ce)
        begin
            cfg_q <= cfg_d;
            commit_q <= commit_d;
        end
    end

    assign active_cfg = cfg_q;
    assign commit_pulse = commit_q;

    // ------------------------------------------------------------
    // Per-channel fill muting.
    // ------------------------------------------------------------
    logic right_filling;
    logic left_filling;

    // Each channel reloads only when its own delay changes.
    dcc_fill_mute u_right_fill (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .load(commit_d && cfg_d.right_delay != cfg_q.right_delay),
        .load_value(cfg_d.right_delay),
        .sample_tick(right_sample_tick),
        .filling(right_filling)
    );

    dcc_fill_mute u_left_fill (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .load(commit_d && cfg_d.left_delay != cfg_q.left_delay),
        .load_value(cfg_d.left_delay),
        .sample_tick(left_sample_tick),
        .filling(left_filling)
    );

    // Control mute bits bypass the commit path entirely.
    assign right_mute = regs_q[dcc_pkg::DCC_OFS_CTRL][dcc_pkg::DCC_CTRL_MUTE_R_BIT] | right_filling;
    assign left_mute = regs_q[dcc_pkg::DCC_OFS_CTRL][dcc_pkg::DCC_CTRL_MUTE_L_BIT] | left_filling;

endmodule : dcc_regs

//--- verification/dcc_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Two-wire bus master acting as the host.
// ------------------------------------------------------------
module dcc_host_model (
    // Clock.
    input wire logic clk,
    // Resolved data line.
    input wire logic sda_line,
    // Driven pins; a one releases the line.
    output logic scl_q,
    output logic sda_q
);
    logic nack_q; // Set when a byte sent was not acknowledged.
    logic [7:0] rx_q [0:7]; // Bytes of the last read.
    initial
    begin
        scl_q = 1'b1;
        sda_q = 1'b1;
        nack_q = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold
    // Twelve-clock phases leave margin over the input filter delay.
    task automatic bit_x(input logic b, output logic r);
        hold(6);
        sda_q <= b;
        hold(6);
        scl_q <= 1'b1;
        hold(12);
        r = sda_line;
        scl_q <= 1'b0;
    endtask : bit_x
    // A one makes a start or repeated start, a zero a stop.
    task automatic cond(input logic s);
        hold(6);
        sda_q <= s;
        hold(6);
        scl_q <= 1'b1;
        hold(12);
        sda_q <= ~s;
        hold(12);
        scl_q <= ~s;
    endtask : cond
    // Eight bits and the acknowledge slot; w marks a byte the host sends.
    task automatic byte_x(input logic [7:0] d, input logic m, input logic w, output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(m, a);
        nack_q = nack_q | (w & a);
    endtask : byte_x
    task automatic wr(input logic [6:0] a, input logic [3:0] p, input int n, input logic [7:0] d [0:7]);
        logic [7:0] q;
        nack_q = 1'b0;
        cond(1'b1);
        byte_x({a, 1'b0}, 1'b1, 1'b1, q);
        byte_x({4'h0, p}, 1'b1, 1'b1, q);
        for (int i = 0; i < n; i++)
            byte_x(d[i], 1'b1, 1'b1, q);
        cond(1'b0);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [3:0] p, input int n);
        logic [7:0] q;
        nack_q = 1'b0;
        cond(1'b1);
        byte_x({a, 1'b0}, 1'b1, 1'b1, q);
        byte_x({4'h0, p}, 1'b1, 1'b1, q);
        cond(1'b1);
        byte_x({a, 1'b1}, 1'b1, 1'b1, q);
        for (int i = 0; i < n; i++)
            byte_x(8'hFF, i == n - 1, 1'b0, rx_q[i]);
        cond(1'b0);
    endtask : rd
endmodule : dcc_host_model

//--- verification/dcc_regs_checker.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the register block.
// ------------------------------------------------------------
module dcc_regs_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Bus pins.
    input wire logic scl_i,
    input wire logic sda_oe_n,
    // Sample strobes.
    input wire logic right_sample_tick,
    input wire logic left_sample_tick,
    // Live settings and mutes.
    input wire dcc_pkg::dcc_cfg_t active_cfg,
    input wire logic commit_pulse,
    input wire logic right_mute,
    input wire logic left_mute
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // A commit is one lone pulse.
    sequence s_pulse;
        commit_pulse ##1 !commit_pulse;
    endsequence
    // A channel has just taken a new nonzero delay.
    sequence s_new_r;
        $changed(active_cfg.right_delay) && (active_cfg.right_delay != 13'h0000);
    endsequence
    sequence s_new_l;
        $changed(active_cfg.left_delay) && (active_cfg.left_delay != 13'h0000);
    endsequence
    AST_PULSE_SINGLE: assert property (commit_pulse |-> s_pulse)
        else $error("commit pulse longer than one cycle");
    AST_CFG_WITH_PULSE: assert property ($changed(active_cfg) |-> commit_pulse || $past(commit_pulse))
        else $error("live settings moved without a commit");
    AST_CFG_SCL_LOW: assert property ($changed(active_cfg) |-> !scl_i)
        else $error("live settings moved outside a byte end");
    AST_FRAME_DELAY: assert property (active_cfg.frame_mode |-> (active_cfg.right_delay == active_cfg.left_delay)
        && (active_cfg.left_delay == dcc_pkg::dcc_frame_samples(active_cfg.frame_setting)))
        else $error("frame mode delay wrong");
    AST_LEN_CLAMP: assert property (active_cfg.right_aligned_format_len <= dcc_pkg::DCC_LEN_MAX)
        else $error("packet length above limit");
    AST_FILL_R: assert property (s_new_r |-> ##[0:2] right_mute)
        else $error("right not muted after new delay");
    AST_FILL_L: assert property (s_new_l |-> ##[0:2] left_mute)
        else $error("left not muted after new delay");
    AST_MUTE_FALL_R: assert property ($fell(right_mute) |-> $past(right_sample_tick) || !scl_i)
        else $error("right mute dropped without cause");
    AST_MUTE_FALL_L: assert property ($fell(left_mute) |-> $past(left_sample_tick) || !scl_i)
        else $error("left mute dropped without cause");
    AST_SDA_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_i)
        else $error("data line moved while clock high");
endmodule : dcc_regs_checker

bind dcc_regs dcc_regs_checker u_chk (
    .clk(clk), .reset(reset), .scl_i(scl_i), .sda_oe_n(sda_oe_n),
    .right_sample_tick(right_sample_tick), .left_sample_tick(left_sample_tick), .active_cfg(active_cfg),
    .commit_pulse(commit_pulse), .right_mute(right_mute), .left_mute(left_mute)
);

//--- verification/tb_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench for the register block.
// ------------------------------------------------------------
module tb_top;
    // Bytes for 0x01..0x07 beside the live settings they give.
    typedef struct packed {
        logic [55:0] regs;
        dcc_pkg::dcc_cfg_t cfg;
    } dcc_row_t;
    localparam logic [6:0] DEV = {dcc_pkg::DCC_BUS_ADDR_BASE, 3'h1};
    logic clk;
    logic reset;
    logic rtick;
    logic ltick;
    logic scl;
    logic sda_m;
    logic sda_o;
    logic sda_oe_n;
    logic commit_pulse;
    logic rmute;
    logic lmute;
    wire sda_line;
    dcc_pkg::dcc_cfg_t cfg;
    dcc_pkg::dcc_cfg_t prev;
    dcc_row_t rows [0:3];
    logic [7:0] d [0:7];
    int error_cnt;
    int comparisons;
    int commit_cnt = 0;
    // Open-drain line with a pull-up.
    assign sda_line = sda_m & (sda_oe_n | sda_o);
    dcc_regs u_dut (
        .clk(clk), .reset(reset), .ce(1'b1), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .addr_pins(3'h1), .right_sample_tick(rtick), .left_sample_tick(ltick),
        .active_cfg(cfg), .commit_pulse(commit_pulse), .right_mute(rmute), .left_mute(lmute)
    );
    dcc_host_model u_host (.clk(clk), .sda_line(sda_line), .scl_q(scl), .sda_q(sda_m));
    // Counts commit strobes mid-cycle, where they stand settled.
    always @(negedge clk) if (commit_pulse) commit_cnt++;
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic put(input logic [3:0] p, input logic [7:0] b);
        d[0] = b;
        u_host.wr(DEV, p, 1, d);
    endtask : put
    // One-cycle sample strobes, n times, then settle to mid-cycle.
    task automatic tick(input logic r, input logic l, input int n);
        repeat (n)
        begin
            @(posedge clk);
            rtick <= r;
            ltick <= l;
            @(posedge clk);
            rtick <= 1'b0;
            ltick <= 1'b0;
        end
        @(negedge clk);
    endtask : tick
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Cuts a hang short.
    initial
    begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        reset = 1'b1;
        rtick = 1'b0;
        ltick = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        prev = '0;
        rows[0] = {56'h00_00_23_01_2C_00_00, 2'h0, 1'h0, 7'h00, 6'h00, 13'h0023, 13'h012C};
        rows[1] = {56'h01_FF_FF_00_00_00_3F, 2'h1, 1'h0, 7'h00, 6'h18, 13'h1FFF, 13'h0000};
        rows[2] = {56'h02_0F_FF_10_00_90_10, 2'h2, 1'h1, 7'h10, 6'h10, 13'h03C0, 13'h03C0};
        rows[3] = {56'h03_00_00_00_00_F7_18, 2'h3, 1'h1, 7'h77, 6'h18, 13'h1FFF, 13'h1FFF};
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        // Every format, full burst, then commit.
        foreach (rows[i])
        begin
            for (int k = 0; k < 7; k++)
                d[k] = rows[i].regs[55 - 8 * k -: 8];
            u_host.wr(DEV, 4'h1, 7, d);
            check(cfg, prev);
            put(4'h8, 8'h01);
            check(cfg, rows[i].cfg);
            check(u_host.nack_q, 1'b0);
            prev = rows[i].cfg;
        end
        // Clear bit zero holds; upper bits are ignored on commit.
        put(4'h6, 8'h00);
        put(4'h8, 8'h00);
        check(cfg, prev);
        put(4'h8, 8'hFE);
        check(cfg, prev);
        put(4'h8, 8'hFF);
        prev = {2'h3, 1'h0, 7'h00, 6'h18, 13'h0000, 13'h0000};
        check(cfg, prev);
        put(4'h6, 8'hF7);
        check(cfg, prev);
        // Sequential read back, then the unused pointer and a foreign address.
        u_host.rd(DEV, 4'h1, 8);
        for (int k = 0; k < 8; k++)
            check(u_host.rx_q[k], 64'h03_00_00_00_00_F7_18_FF >> (56 - 8 * k) & 64'hFF);
        u_host.rd(DEV, 4'h0, 1);
        check(u_host.rx_q[0], 8'h00);
        u_host.wr(DEV ^ 7'h03, 4'h1, 1, d);
        check(u_host.nack_q, 1'b1);
        // Each channel stays muted until its own delay has filled.
        d = '{8'h00, 8'h00, 8'h23, 8'h01, 8'h2C, 8'h00, 8'h00, 8'h00};
        u_host.wr(DEV, 4'h1, 7, d);
        put(4'h8, 8'h01);
        tick(1'b1, 1'b1, 34);
        check({rmute, lmute}, 2'b11);
        tick(1'b1, 1'b1, 1);
        check({rmute, lmute}, 2'b01);
        tick(1'b0, 1'b1, 264);
        check(lmute, 1'b1);
        tick(1'b0, 1'b1, 1);
        check(lmute, 1'b0);
        // Mute pairs act at once, with no commit.
        for (int m = 0; m < 4; m++)
        begin
            put(4'h1, {m[1:0], 6'h00});
            check({rmute, lmute}, m[1:0]);
        end
        check(commit_cnt, 6);
        print_verdict();
    end
endmodule : tb_top
